//--- dv/analog_front_model.sv
`timescale 1ns/1ps
// Analog side: input levels tracked while sampling and held after, SAR comparator
module analog_front_model
	import sar_seq_pkg::*;
(
	// Converter side
	input  wire logic             clock,
	input  wire logic [CH_W:0]    mux,
	input  wire logic [RES_W-1:0] dac,
	input  wire logic             hold,
	input  wire logic             bias,
	// Comparator result
	output logic                  cmp
);
	logic [RES_W-1:0] lvl_r;
	// Track the selected input while the sample switch is closed
	always_ff @(posedge clock) begin
		if (hold) begin
			// Sensor reads zero with its bias off
			lvl_r <= (mux == TEMP_SEL && !bias) ? 12'h000 :
				{mux, 8'h5A};
		end
	end
	// Trial bit kept when the held level is at or above it
	assign cmp = (lvl_r >= dac);
endmodule

//--- dv/sar_seq_props.sv
`timescale 1ns/1ps
// Port-level timing checks of the scan sequencer
module sar_seq_props
	import sar_seq_pkg::*;
#(
	parameter int unsigned NCH = NUM_CH
)(
	// Clock and reset
	input wire logic            clock,
	input wire logic            rst_n,
	// Inputs
	input wire logic            enable,
	input wire logic            low_power_mode,
	input wire logic [1:0]      ref_select,
	input wire logic [NCH-1:0]  chan_enable,
	input wire logic            temp_bias_off,
	input wire logic            fw_mode,
	input wire logic            scan_start,
	input wire logic            range_clear,
	input wire logic            scan_clear,
	// Outputs
	input wire logic            sample_hold,
	input wire logic [CH_W:0]   converter_input_mux,
	input wire logic [1:0]      ref_sel_out,
	input wire logic            temp_bias_en,
	input wire logic            busy,
	input wire logic            range_flag,
	input wire logic            scan_done
);
	logic [9:0] hold_cnt_r;
	logic [9:0] conv_cnt_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Acquisition length, and spacing of sample starts saturating at 10'h3FF
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_r <= 10'h000;
			conv_cnt_r <= 10'h3FF;
		end else begin
			hold_cnt_r <= sample_hold ? hold_cnt_r + 10'h001 : 10'h000;
			conv_cnt_r <= $rose(sample_hold) ? 10'h000 :
				conv_cnt_r + 10'(conv_cnt_r != 10'h3FF);
		end
	end
	sequence s_go;
		scan_start && !busy && enable && !low_power_mode && !fw_mode
			&& (|chan_enable);
	endsequence
	sequence s_next;
		busy && $past(busy) && !low_power_mode
			&& $changed(converter_input_mux);
	endsequence
	property p_bias;
		$past(rst_n) |-> temp_bias_en == !$past(temp_bias_off);
	endproperty
	property p_ref;
		$past(rst_n) |-> ref_sel_out == $past(ref_select);
	endproperty
	property p_lp_stop;
		low_power_mode |-> ##[0:3] !busy;
	endproperty
	property p_lp_hold;
		low_power_mode && !busy |=> !busy;
	endproperty
	property p_start;
		s_go |-> ##[1:3] busy;
	endproperty
	property p_gap;
		s_next |-> ##[0:15] sample_hold;
	endproperty
	property p_conv;
		$rose(sample_hold) |-> conv_cnt_r >= 10'd250;
	endproperty
	property p_hold;
		$fell(sample_hold) && !low_power_mode |-> hold_cnt_r >= 10'd82;
	endproperty
	property p_mux;
		busy |-> converter_input_mux <= TEMP_SEL;
	endproperty
	property p_flag;
		range_flag && !range_clear |=> range_flag;
	endproperty
	property p_done;
		scan_done && !scan_clear |=> scan_done;
	endproperty
	a_bias: assert property (p_bias) else $error("bias enable wrong");
	a_ref: assert property (p_ref) else $error("reference wrong");
	a_lp_stop: assert property (p_lp_stop) else $error("no halt");
	a_lp_hold: assert property (p_lp_hold) else $error("ran asleep");
	a_start: assert property (p_start) else $error("scan not begun");
	a_gap: assert property (p_gap) else $error("idle switch gap");
	a_conv: assert property (p_conv) else $error("conversion short");
	a_hold: assert property (p_hold) else $error("sample too short");
	a_mux: assert property (p_mux) else $error("bad input select");
	a_flag: assert property (p_flag) else $error("range flag lost");
	a_done: assert property (p_done) else $error("done flag lost");
endmodule
bind sar_adc_sequencer_control sar_seq_props #(.NCH(NCH)) props_i (.clock,
	.rst_n, .enable, .low_power_mode, .ref_select, .chan_enable,
	.temp_bias_off, .fw_mode, .scan_start, .range_clear, .scan_clear,
	.sample_hold, .converter_input_mux, .ref_sel_out, .temp_bias_en,
	.busy, .range_flag, .scan_done);

//--- dv/tb_sar_adc_sequencer_control.sv
`timescale 1ns/1ps
// Self-checking bench for the scan sequencer
module tb_sar_adc_sequencer_control;
	import sar_seq_pkg::*;
	logic clock = 0, rst_n = 0, enable = 1, low_power_mode = 0;
	logic continuous = 0, temp_enable = 0, temp_bias_off = 0, fw_mode = 0;
	logic scan_start = 0, fw_select_valid = 0, range_clear = 0;
	logic scan_clear = 0, comparator, sample_hold, temp_bias_en, busy;
	logic range_flag, scan_done, sh_q = 0;
	logic [1:0] ref_select = 0, ref_sel_out;
	logic [7:0] chan_enable = 0, temp_samp_time = 8'h08;
	logic [63:0] samp_time = 64'h1412_100E_0C0A_0806;
	logic [11:0] limit_low = 0, limit_high = 12'hFFF, rd_data, dac_code;
	logic [3:0] fw_select = 0, rd_chan = 0, converter_input_mux;
	logic [8:0] range_chan;
	int bad_count = 0, samples_checked = 0, hl[0:8];
	logic [3:0] order[$];
	sar_adc_sequencer_control sar_adc_sequencer_control_i (.clock, .rst_n,
		.enable, .low_power_mode, .ref_select, .chan_enable, .samp_time,
		.temp_enable, .temp_samp_time, .temp_bias_off, .limit_low,
		.limit_high, .fw_mode, .scan_start, .continuous, .fw_select_valid,
		.fw_select, .range_clear, .scan_clear, .rd_chan, .rd_data,
		.comparator, .dac_code, .sample_hold, .converter_input_mux,
		.ref_sel_out, .temp_bias_en, .busy, .range_flag, .range_chan,
		.scan_done);
	analog_front_model analog_front_model_i (.clock, .mux(converter_input_mux),
		.dac(dac_code), .hold(sample_hold), .bias(temp_bias_en),
		.cmp(comparator));
	// Clock, 4 ns period
	always #2 clock = ~clock;
	// Record acquisition order and length per input
	always @(posedge clock) begin
		sh_q <= sample_hold;
		if (sample_hold === 1'b1 && converter_input_mux <= 4'h8) begin
			hl[converter_input_mux] <= hl[converter_input_mux] + 1;
			if (!sh_q) order.push_back(converter_input_mux);
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for busy to reach a level
	task automatic wait_busy(input logic lvl);
		for (int n = 0; n < 3000 && busy !== lvl; n++) @(negedge clock);
		if (busy !== lvl) begin
			bad_count++;
			finish_test();
		end
	endtask
	task automatic rd(input logic [3:0] ch, input logic [11:0] exp);
		rd_chan = ch;
		@(negedge clock);
		check(16'(rd_data), 16'(exp));
	endtask
	task automatic t_reset();
		check(16'({busy, scan_done, range_flag, temp_bias_en}), 16'h1);
		for (int r = 0; r < 4; r++) begin
			ref_select = 2'(r);
			repeat (2) @(negedge clock);
			check(16'(ref_sel_out), 16'(r));
		end
	endtask
	task automatic t_scan();
		chan_enable = 8'h89;
		temp_enable = 1;
		limit_low = 12'h200;
		limit_high = 12'h600;
		hl = '{default: 0};
		scan_start = 1;
		@(negedge clock);
		scan_start = 0;
		wait_busy(1);
		for (int n = 0; n < 3000 && range_flag !== 1'b1; n++) @(negedge clock);
		if (range_flag !== 1'b1) begin
			bad_count++;
			finish_test();
		end
		check(16'({range_flag, scan_done}), 16'h2);
		wait_busy(0);
		check(16'(scan_done), 16'h1);
		check(16'(range_chan), 16'h181);
		check(16'(order.size()), 16'h4);
		foreach (order[i])
			check(16'(order[i]), 16'(i == 3 ? 8 : i * 4 - (i > 0)));
		check(16'((hl[0] - 1) / CONV_DIV), 16'h6);
		check(16'((hl[7] - 1) / CONV_DIV), 16'h14);
		rd(4'h0, 12'h05A);
		rd(4'h3, 12'h35A);
		rd(4'h7, 12'h75A);
		rd(4'h8, 12'h85A);
		rd(4'h9, 12'h000);
		range_clear = 1;
		scan_clear = 1;
		@(negedge clock);
		{range_clear, scan_clear} = 0;
		@(negedge clock);
		check(16'({range_flag, scan_done}), 16'h0);
	endtask
	task automatic t_fw();
		fw_mode = 1;
		for (int k = 0; k < 2; k++) begin
			fw_select = k ? 4'h5 : 4'h9;
			fw_select_valid = 1;
			@(negedge clock);
			fw_select_valid = 0;
			repeat (4) @(negedge clock);
			check(16'(busy), 16'(k));
		end
		wait_busy(0);
		rd(4'h5, 12'h55A);
		fw_mode = 0;
	endtask
	task automatic t_lowpow();
		temp_bias_off = 1;
		repeat (2) @(negedge clock);
		check(16'(temp_bias_en), 16'h0);
		for (int k = 0; k < 2; k++) begin
			scan_start = 1;
			@(negedge clock);
			scan_start = 0;
			if (k == 0) wait_busy(1);
			low_power_mode = 1;
			repeat (5) @(negedge clock);
			check(16'(busy), 16'h0);
		end
		low_power_mode = 0;
	endtask
	initial begin
		repeat (20) @(negedge clock);
		rst_n = 1;
		@(negedge clock);
		t_reset();
		t_scan();
		t_fw();
		t_lowpow();
		finish_test();
	end
endmodule

//--- rtl/sar_adc_sequencer_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Conversion clock at most 18 MHz; 12-bit result takes 18+ clocks.
// - Next channel starts right after a result; no idle cycles.
// - Reference select picks supply, half supply, bandgap or external pin.
// - Acquisition window length is a programmable count.
// - Eight fixed inputs, each individually enabled for the scan.
// - Once started, the sequencer converts every enabled channel by itself.
// - Channel stepping by state machine, or by software choosing next.
// - Each channel keeps its latest result in its own buffer.
// - Each channel has its own sample time, applied when converting it.
// - Low and high limits; result outside them raises out-of-range flag.
// - Range check applied per result as it is produced.
// - Temperature sensor selectable and converted like any other channel.
// - Converter halted while chip is in deep sleep or hibernate.
// - Control bit switches off the temperature sensor bias current.
module sar_adc_sequencer_control
	import sar_seq_pkg::*;
#(
	parameter int unsigned NCH = NUM_CH
)(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// Configuration
	input  wire logic                   enable,
	input  wire logic                   low_power_mode,
	input  wire logic [1:0]             ref_select,
	input  wire logic [NCH-1:0]         chan_enable,
	input  wire logic [NCH*SAMP_W-1:0]  samp_time,
	input  wire logic                   temp_enable,
	input  wire logic [SAMP_W-1:0]      temp_samp_time,
	input  wire logic                   temp_bias_off,
	input  wire logic [RES_W-1:0]       limit_low,
	input  wire logic [RES_W-1:0]       limit_high,
	input  wire logic                   fw_mode,
	// Commands
	input  wire logic                   scan_start,
	input  wire logic                   continuous,
	input  wire logic                   fw_select_valid,
	input  wire logic [CH_W:0]          fw_select,
	input  wire logic                   range_clear,
	input  wire logic                   scan_clear,
	// Result read port
	input  wire logic [CH_W:0]          rd_chan,
	output logic [RES_W-1:0]            rd_data,
	// Analog side
	input  wire logic                   comparator,
	output logic [RES_W-1:0]            dac_code,
	output logic                        sample_hold,
	output logic [CH_W:0]               converter_input_mux,
	output logic [1:0]                  ref_sel_out,
	output logic                        temp_bias_en,
	// Status
	output logic                        busy,
	output logic                        range_flag,
	output logic [NCH:0]                range_chan,
	output logic                        scan_done
);
	sar_core_if core ();

	// Conversion clock divider and sequencer state
	logic [DIV_W-1:0]  div_r, div_nxt;
	logic              tick_r, tick_nxt;
	seq_state_e        st_r, st_nxt;
	logic [CH_W:0]     ch_r, ch_nxt;
	logic              run_r, run_nxt;
	logic              start_r, start_nxt;
	logic              mux_hold_r, mux_hold_nxt;
	// Status and results
	logic [RES_W-1:0]  buf_r [NCH+1];
	logic [RES_W-1:0]  rd_r, rd_nxt;
	logic              rflag_r, rflag_nxt;
	logic [NCH:0]      rch_r, rch_nxt;
	logic              sdone_r, sdone_nxt;
	logic [RES_W-1:0]  dac_r;
	logic              sh_r;
	logic [1:0]        ref_r;
	logic              bias_r;
	logic              busy_r;
	logic              active;
	logic [NCH:0]      en_all;
	logic [CH_W:0]     next_ch;
	logic              has_next;
	logic              out_of_range;

	// Lowest enabled channel above the given one; temperature last
	function automatic logic [CH_W+1:0] find_next(input logic [NCH:0] en,
			input logic [CH_W:0] from, input logic incl);
		logic [CH_W+1:0] res;
		res = '1;
		for (int i = NCH; i >= 0; i--) begin
			if (en[i] && ((CH_W+1)'(i) > {1'b0, from} ||
					(incl && (CH_W+1)'(i) == {1'b0, from})))
				res = (CH_W+2)'(i);
		end
		return res;
	endfunction

	// Sample length of a channel, counted in conversion clocks
	function automatic logic [CNT_W-1:0] samp_of(input logic [CH_W:0] ch,
			input logic [NCH*SAMP_W-1:0] st, input logic [SAMP_W-1:0] ts);
		logic [SAMP_W-1:0] v;
		v = (ch == TEMP_SEL) ? ts : st[ch[CH_W-1:0]*SAMP_W +: SAMP_W];
		// Floor keeps a conversion at no fewer than 18 clocks
		if (v < SAMP_W'(CONV_CLOCKS - RES_W))
			v = SAMP_W'(CONV_CLOCKS - RES_W);
		if (v > SAMP_W'({CNT_W{1'b1}}))
			v = SAMP_W'({CNT_W{1'b1}});
		return v[CNT_W-1:0];
	endfunction

	assign active   = enable && !low_power_mode;
	assign en_all   = {temp_enable, chan_enable};
	assign out_of_range = (core.code < limit_low) ||
		(core.code > limit_high);

	// Next channel in the scan order
	always_comb begin
		logic [CH_W+1:0] f;
		f = find_next(en_all, ch_r, 1'b0);
		has_next = !f[CH_W+1];
		next_ch  = f[CH_W:0];
	end

	// Engine drive
	assign core.tick     = tick_r;
	assign core.start    = start_r;
	assign core.cmp_out  = comparator;
	// Acquisition length follows the channel now selected
	assign core.samp_len = samp_of(ch_r, samp_time,
		temp_samp_time);
	// Sleep or disable aborts a conversion in flight
	assign core.stop     = !active;

	sar_bit_engine u_engine (
		.clock (clock),
		.rst_n (rst_n),
		.bus   (core)
	);

	// Conversion clock enable at no more than 18 MHz
	always_comb begin
		if (div_r == DIV_W'(CONV_DIV - 1)) begin
			div_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			div_nxt  = div_r + DIV_W'(1);
			tick_nxt = 1'b0;
		end
	end

	// Sequencer next state
	always_comb begin
		logic [CH_W+1:0] first;
		first     = find_next(en_all, '0, 1'b1);
		st_nxt    = st_r;
		ch_nxt    = ch_r;
		run_nxt   = run_r;
		start_nxt = 1'b0;
		sdone_nxt = sdone_r && !scan_clear;
		rflag_nxt = rflag_r && !range_clear;
		rch_nxt   = range_clear ? '0 : rch_r;
		mux_hold_nxt = mux_hold_r;
		unique case (st_r)
			ST_IDLE: begin
				if (active && fw_mode && fw_select_valid &&
						fw_select <= TEMP_SEL) begin
					ch_nxt    = fw_select;
					start_nxt = 1'b1;
					st_nxt    = ST_SAMPLE;
				end else if (active && !fw_mode && scan_start &&
						!first[CH_W+1]) begin
					ch_nxt    = first[CH_W:0];
					run_nxt   = 1'b1;
					start_nxt = 1'b1;
					st_nxt    = ST_SAMPLE;
				end
			end
			// Engine takes the start strobe here
			ST_SAMPLE: st_nxt = ST_CONVERT;
			// Wait for the result, then pick the next input
			ST_CONVERT: begin
				if (!active) begin
					st_nxt  = ST_IDLE;
					run_nxt = 1'b0;
				end else if (core.done) begin
					// Flag as each result lands
					if (out_of_range) begin
						rflag_nxt = 1'b1;
						rch_nxt[ch_r] = 1'b1;
					end
					if (fw_mode || !run_r) begin
						st_nxt  = ST_IDLE;
						run_nxt = 1'b0;
					end else if (has_next) begin
						// Restart in the same cycle: no gap
						ch_nxt    = next_ch;
						start_nxt = 1'b1;
						st_nxt    = ST_SAMPLE;
					end else begin
						sdone_nxt = 1'b1;
						if (continuous && !first[CH_W+1]) begin
							ch_nxt    = first[CH_W:0];
							start_nxt = 1'b1;
							st_nxt    = ST_SAMPLE;
						end else begin
							st_nxt  = ST_IDLE;
							run_nxt = 1'b0;
						end
					end
				end
			end
			// Unused state code falls back to idle
			default: begin
				st_nxt  = ST_IDLE;
				run_nxt = 1'b0;
			end
		endcase
		// Input switch stays closed while a conversion is pending
		mux_hold_nxt = (st_nxt != ST_IDLE);
	end

	// Result read mux
	always_comb begin
		rd_nxt = (rd_chan <= TEMP_SEL) ? buf_r[rd_chan] : '0;
	end

	// Sequencer and status registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_r      <= '0;
			tick_r     <= 1'b0;
			st_r       <= ST_IDLE;
			ch_r       <= '0;
			run_r      <= 1'b0;
			start_r    <= 1'b0;
			mux_hold_r <= 1'b0;
			rflag_r    <= 1'b0;
			rch_r      <= '0;
			sdone_r    <= 1'b0;
			rd_r       <= '0;
		end else begin
			div_r      <= div_nxt;
			tick_r     <= tick_nxt;
			st_r       <= st_nxt;
			ch_r       <= ch_nxt;
			run_r      <= run_nxt;
			start_r    <= start_nxt;
			mux_hold_r <= mux_hold_nxt;
			rflag_r    <= rflag_nxt;
			rch_r      <= rch_nxt;
			sdone_r    <= sdone_nxt;
			rd_r       <= rd_nxt;
		end
	end

	// Per-channel result buffers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i <= NCH; i++)
				buf_r[i] <= '0;
		end else if (st_r == ST_CONVERT && core.done) begin
			buf_r[ch_r] <= core.code;
		end
	end

	// Registered analog controls
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dac_r  <= '0;
			sh_r   <= 1'b0;
			ref_r  <= REF_VDD;
			bias_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			dac_r  <= core.dac_code;
			sh_r   <= core.hold;
			ref_r  <= ref_select;
			bias_r <= !temp_bias_off;
			busy_r <= (st_r != ST_IDLE) || core.busy;
		end
	end

	assign rd_data             = rd_r;
	assign dac_code            = dac_r;
	assign sample_hold         = sh_r;
	assign converter_input_mux = ch_r;
	assign ref_sel_out         = ref_r;
	assign temp_bias_en        = bias_r;
	assign busy                = busy_r;
	assign range_flag          = rflag_r;
	assign range_chan          = rch_r;
	assign scan_done           = sdone_r;
endmodule

//--- rtl/sar_bit_engine.sv
`timescale 1ns/1ps
// Successive-approximation engine: acquisition window, then 12 bit trials
module sar_bit_engine
	import sar_seq_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Sequencer side
	sar_core_if.core  bus
);
	typedef enum logic [1:0] {E_IDLE, E_ACQ, E_BITS} eng_state_e;
	eng_state_e       st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [RES_W-1:0] trial_r, trial_nxt;
	logic [RES_W-1:0] bit_r, bit_nxt;
	logic             done_r, done_nxt;

	// Next state of the engine
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		trial_nxt = trial_r;
		bit_nxt   = bit_r;
		done_nxt  = 1'b0;
		unique case (st_r)
			E_IDLE: begin
				if (bus.start) begin
					st_nxt  = E_ACQ;
					cnt_nxt = bus.samp_len;
				end
			end
			E_ACQ: begin
				if (bus.tick) begin
					// One tick beyond the count: the first tick may land
					// part-way into a conversion clock
					if (cnt_r == '0) begin
						st_nxt    = E_BITS;
						cnt_nxt   = BIT_CLOCKS;
						bit_nxt   = {1'b1, {(RES_W-1){1'b0}}};
						trial_nxt = {1'b1, {(RES_W-1){1'b0}}};
					end else begin
						cnt_nxt = cnt_r - CNT_W'(1);
					end
				end
			end
			E_BITS: begin
				if (bus.tick) begin
					// Keep or drop the trial bit from the comparator
					trial_nxt = bus.cmp_out ? trial_r : (trial_r & ~bit_r);
					trial_nxt = trial_nxt | (bit_r >> 1);
					bit_nxt   = bit_r >> 1;
					cnt_nxt   = cnt_r - CNT_W'(1);
					if (cnt_r == CNT_W'(1)) begin
						st_nxt   = E_IDLE;
						done_nxt = 1'b1;
					end
				end
			end
			default: st_nxt = E_IDLE;
		endcase
		// Leaving the active state drops the conversion at once
		if (bus.stop) begin
			st_nxt   = E_IDLE;
			done_nxt = 1'b0;
		end
	end

	// Engine registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= E_IDLE;
			cnt_r   <= '0;
			trial_r <= '0;
			bit_r   <= '0;
			done_r  <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			trial_r <= trial_nxt;
			bit_r   <= bit_nxt;
			done_r  <= done_nxt;
		end
	end

	assign bus.busy     = (st_r != E_IDLE);
	assign bus.hold     = (st_r == E_ACQ);
	assign bus.done     = done_r;
	assign bus.code     = trial_r;
	assign bus.dac_code = trial_r;
endmodule

//--- rtl/sar_core_if.sv
`timescale 1ns/1ps
interface sar_core_if;
	import sar_seq_pkg::*;
	logic              tick;
	logic [CNT_W-1:0]  samp_len;
	logic              start;
	logic              busy;
	logic              done;
	logic [RES_W-1:0]  code;
	logic              hold;
	logic              cmp_out;
	logic [RES_W-1:0]  dac_code;
	logic              stop;
	modport seq  (output tick, samp_len, start, stop, input busy, done, code,
		hold, dac_code, output cmp_out);
	modport core (input tick, samp_len, start, stop, cmp_out, output busy,
		done, code, hold, dac_code);
endinterface

//--- rtl/sar_seq_pkg.sv
package sar_seq_pkg;
	// Converter geometry
	localparam int unsigned NUM_CH        = 8;
	localparam int unsigned CH_W          = 3;
	localparam int unsigned RES_W         = 12;
	localparam int unsigned SAMP_W        = 8;
	// Conversion clock limit and conversion length
	localparam int unsigned SYS_CLK_MHZ   = 250;
	localparam int unsigned CONV_CLK_MHZ  = 18;
	localparam int unsigned CONV_CLOCKS   = 18;
	// System clocks per conversion clock, least figure rounded up
	localparam int unsigned CONV_DIV      =
		(SYS_CLK_MHZ + CONV_CLK_MHZ - 1) / CONV_CLK_MHZ;
	localparam int unsigned DIV_W         = 5;
	localparam int unsigned CNT_W         = 5;
	// Bit-decision clocks after acquisition
	localparam logic [CNT_W-1:0] BIT_CLOCKS = CNT_W'(RES_W);
	// Reference select encodings
	localparam logic [1:0] REF_VDD        = 2'h0;
	localparam logic [1:0] REF_VDD_HALF   = 2'h1;
	localparam logic [1:0] REF_BANDGAP    = 2'h2;
	localparam logic [1:0] REF_EXTERNAL   = 2'h3;
	// Mux code of the temperature sensor input
	localparam logic [CH_W:0] TEMP_SEL    = 4'h8;
	// Reset values
	localparam logic [SAMP_W-1:0] SAMP_RST = 8'h03;
	localparam logic [RES_W-1:0]  LOW_RST  = 12'h000;
	localparam logic [RES_W-1:0]  HIGH_RST = 12'hFFF;
	// Sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;
endpackage
